/* File: umlsb_pkg.sv */
package umlsb_pkg;
   // ----------------------------------------------------------------
   // register map (index, byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam logic [3:0] IDX_DATA = 4'h0;
   localparam logic [3:0] IDX_MCR = 4'h4;
   localparam logic [3:0] IDX_LSR = 4'h5;
   localparam logic [3:0] IDX_MSR = 4'h6;
   localparam logic [3:0] IDX_SCR = 4'h7;
   localparam logic [3:0] IDX_DLL = 4'h8;
   localparam logic [3:0] IDX_DLH = 4'h9;
   localparam logic [3:0] IDX_CFG = 4'ha;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] MCR_RST = 8'h00;
   localparam logic [7:0] SCR_RST = 8'h00;
   localparam logic [15:0] DIV_RST = 16'h0001;
   localparam logic [11:0] CFG_RST = 12'h003;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int MCR_DTR = 0;
   localparam int MCR_RTS = 1;
   localparam int MCR_USER_OUTPUT_BIT_A = 2;
   localparam int MCR_GATE = 3;
   localparam int MCR_LOOP = 4;
   localparam int CFG_PEN = 2;
   localparam int CFG_EPS = 3;
   localparam int CFG_FIFO = 4;
   localparam int CFG_IE_RDA = 8;
   localparam int CFG_IE_THR = 9;
   localparam int CFG_IE_RLS = 10;
   localparam int CFG_IE_MS = 11;
   // ----------------------------------------------------------------
   // counts and bus response codes
   // ----------------------------------------------------------------
   localparam logic [3:0] MID_TICK = 4'h7;
   localparam logic [3:0] LAST_TICK = 4'hf;
   localparam logic [3:0] HALF_BIT = 4'h7;
   localparam logic [4:0] FIFO_DEPTH = 5'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP, RX_BRKW} umlsb_rx_t;

   function automatic logic [15:0] umlsb_period(input logic [15:0] div);
      return (div == 16'h0000) ? 16'h0003 : div;
   endfunction

   function automatic logic umlsb_idx_ok(input logic [3:0] idx);
      return (idx == IDX_DATA) || ((idx >= IDX_MCR) && (idx <= IDX_CFG));
   endfunction

   function automatic logic umlsb_has_err(input logic [10:0] ent);
      return |ent[10:8];
   endfunction
endpackage

/* File: umlsb_top.sv */
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
// Function
// - request-to-send pin is the inverted control bit, like terminal-ready
// - user bit a drives no pin, only ring in loopback; control bits five to seven read zero
// - interrupt pin is released unless the gate bit is one
// - loopback holds transmit pin at one and feeds transmit into receive
// - loopback maps control bits onto modem inputs; modem output pins go high
// - loopback modem interrupts come from control bits, still enable-gated
// - data ready sets on a received character, clears when all read
// - overrun sets on a lost character, FIFO full drops it, status read clears
// - parity flag set on bad parity, travels with character in FIFO mode
// - framing flag on zero stop bit; receiver resyncs on that zero
// - break flag on a frame of zeros; only one zero character loaded
// - after break, wait for half a bit of line high before restarting
// - overrun, parity, framing or break raise line status interrupt
// - hold-empty sets on move to shifter, clears on write, interrupts
// - transmitter-empty only when holding and shift registers both empty
// - status bit seven: zero without FIFO, else errors held in FIFO
// - modem change bits set on input change, ring on trailing edge
// - any modem change bit raises the modem interrupt when enabled
// - modem bits four to seven show inverted inputs, or control bits
// - scratch byte is plain storage
// - sixteen-bit divisor makes the sixteen-times baud clock
// - divisor write reloads counter; zero, one, two special, else low two
module umlsb_top (
   input logic i_ref_clk,
   input logic i_rst_n,
   input logic [umlsb_pkg::ADDR_W-1:0] i_awaddr,
   input logic i_awvalid,
   output logic o_awready,
   input logic [31:0] i_wdata,
   input logic [3:0] i_wstrb,
   input logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input logic i_bready,
   input logic [umlsb_pkg::ADDR_W-1:0] i_araddr,
   input logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input logic i_rready,
   input logic i_rx,
   input logic i_clear_to_send_in_n,
   input logic i_set_ready_in_n,
   input logic i_ring_in_n,
   input logic i_carrier_in_n,
   output logic o_tx,
   output logic o_request_to_send_out_n,
   output logic o_terminal_ready_out_n,
   output logic o_irq,
   output logic o_irq_oe,
   output logic o_baud16
);
   import umlsb_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [ADDR_W-1:0] awaddr_r;
   logic [7:0] wdata_r;
   logic [3:0] wdhi_r;
   logic wstrb_r;
   logic wr_go, rd_go, wr_ok;
   logic [3:0] wr_idx, rd_idx;
   logic [7:0] mcr_r, scr_r, rd_mux;
   logic [11:0] cfg_r;
   logic [15:0] div_r, div_nxt, per, baud_cnt_r;
   logic div_wr, tick16_r, loop;
   logic [4:0] sy1_r, sy2_r, sy3_r, flt_r;
   logic [3:0] stat, stat_prev_r, dl_r, chg;
   logic rx_in, lsr_rd, msr_rd;
   umlsb_rx_t rx_state_r;
   logic [3:0] samp_r, bitn_r, nbits, tx_samp_r, tx_left_r;
   logic [8:0] sh_r, sh_al;
   logic [7:0] mask, rx_data;
   logic allz_r, brk, rx_pe, rx_evt_r;
   logic [10:0] rx_ent_r, tx_sh_r, top_nxt;
   logic [10:0] mem [16];
   logic [3:0] wr_ptr_r, rd_ptr_r;
   logic [4:0] cnt_r, err_cnt_r;
   logic full, push, pop, ovr, ovw, top_ld, fifo_en;
   logic oe_r, pe_r, fe_r, bi_r;
   logic [7:0] thr_r, tx_dm;
   logic thr_empty_r, tx_busy_r, thr_wr, tx_load, tx_all_empty;
   logic [7:0] line_condition_flags;

   assign loop = mcr_r[MCR_LOOP];
   assign fifo_en = cfg_r[CFG_FIFO];
   assign wr_go = !o_awready && !o_wready && !o_bvalid;
   assign wr_idx = awaddr_r[5:2];
   assign wr_ok = umlsb_idx_ok(wr_idx);
   assign rd_go = i_arvalid && o_arready;
   assign rd_idx = i_araddr[5:2];
   assign lsr_rd = rd_go && (rd_idx == IDX_LSR);
   assign msr_rd = rd_go && (rd_idx == IDX_MSR);

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_awready <= 1'b1;
         o_wready <= 1'b1;
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
         awaddr_r <= '0;
         wdata_r <= 8'h00;
         wdhi_r <= 4'h0;
         wstrb_r <= 1'b0;
      end else begin
         if (i_awvalid && o_awready) begin
            awaddr_r <= i_awaddr;
            o_awready <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            wdata_r <= i_wdata[7:0];
            wdhi_r <= i_wdata[11:8];
            wstrb_r <= i_wstrb[0];
            o_wready <= 1'b0;
         end
         if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
         end
      end
   end

   always_comb begin
      rd_mux = 8'h00;
      unique case (rd_idx)
         IDX_DATA: rd_mux = (cnt_r != 5'h00) ? mem[rd_ptr_r][7:0] : 8'h00;
         IDX_MCR: rd_mux = {3'b000, mcr_r[4:0]};
         IDX_LSR: rd_mux = line_condition_flags;
         IDX_MSR: rd_mux = {stat, dl_r};
         IDX_SCR: rd_mux = scr_r;
         IDX_DLL: rd_mux = div_r[7:0];
         IDX_DLH: rd_mux = div_r[15:8];
         IDX_CFG: rd_mux = cfg_r[7:0];
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= RESP_OKAY;
      end else begin
         if (rd_go) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= {20'h00000, (rd_idx == IDX_CFG) ? cfg_r[11:8] : 4'h0, rd_mux};
            o_rresp <= umlsb_idx_ok(rd_idx) ? RESP_OKAY : RESP_SLVERR;
         end
         if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mcr_r <= MCR_RST;
         scr_r <= SCR_RST;
         cfg_r <= CFG_RST;
      end else if (wr_go && wstrb_r) begin
         unique case (wr_idx)
            IDX_MCR: mcr_r <= {3'b000, wdata_r[4:0]};
            IDX_SCR: scr_r <= wdata_r;
            // interrupt enables ride in bits 11:8, else no source could be unmasked
            IDX_CFG: cfg_r <= {wdhi_r, wdata_r};
            IDX_DLH: ;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // baud divider
   // ----------------------------------------------------------------
   assign div_wr = wr_go && wstrb_r && ((wr_idx == IDX_DLL) || (wr_idx == IDX_DLH));
   assign div_nxt = {(div_wr && wr_idx == IDX_DLH) ? wdata_r : div_r[15:8],
                     (div_wr && wr_idx == IDX_DLL) ? wdata_r : div_r[7:0]};
   assign per = umlsb_period(div_r);

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_r <= DIV_RST;
         baud_cnt_r <= 16'h0000;
         tick16_r <= 1'b0;
         o_baud16 <= 1'b1;
      end else begin
         div_r <= div_nxt;
         tick16_r <= (baud_cnt_r == 16'h0000);
         if (div_wr) begin
            baud_cnt_r <= umlsb_period(div_nxt) - 16'h0001;
         end else if (baud_cnt_r == 16'h0000) begin
            baud_cnt_r <= per - 16'h0001;
         end else begin
            baud_cnt_r <= baud_cnt_r - 16'h0001;
         end
         // one toggles each clock: the input itself cannot be copied
         if (per == 16'h0001) begin
            o_baud16 <= !o_baud16;
         end else if (per == 16'h0002) begin
            o_baud16 <= (baud_cnt_r != 16'h0001);
         end else begin
            o_baud16 <= (baud_cnt_r < per - 16'h0002);
         end
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers and modem status
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sy1_r <= 5'h1f;
         sy2_r <= 5'h1f;
         sy3_r <= 5'h1f;
         flt_r <= 5'h1f;
      end else begin
         sy1_r <= {i_rx, i_carrier_in_n, i_ring_in_n, i_set_ready_in_n, i_clear_to_send_in_n};
         sy2_r <= sy1_r;
         sy3_r <= sy2_r;
         flt_r <= (sy2_r & sy3_r) | (flt_r & (sy2_r ^ sy3_r));
      end
   end

   // loopback order: carrier, ring, set-ready, clear-to-send
   assign stat = loop ? {mcr_r[MCR_GATE], mcr_r[MCR_USER_OUTPUT_BIT_A], mcr_r[MCR_DTR], mcr_r[MCR_RTS]}
                      : ~flt_r[3:0];
   assign chg = {stat[3] ^ stat_prev_r[3], stat_prev_r[2] & !stat[2],
                 stat[1] ^ stat_prev_r[1], stat[0] ^ stat_prev_r[0]};

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stat_prev_r <= 4'h0;
         dl_r <= 4'h0;
      end else begin
         stat_prev_r <= stat;
         dl_r <= chg | (dl_r & {4{!msr_rd}});
      end
   end

   // ----------------------------------------------------------------
   // receiver
   // ----------------------------------------------------------------
   assign rx_in = loop ? tx_sh_r[0] : flt_r[4];
   assign nbits = 4'd5 + {2'b00, cfg_r[1:0]} + {3'b000, cfg_r[CFG_PEN]};
   assign mask = 8'hff >> (2'd3 - cfg_r[1:0]);
   assign sh_al = sh_r >> (4'd9 - nbits);
   assign rx_data = sh_al[7:0] & mask;
   assign rx_pe = cfg_r[CFG_PEN] & (^rx_data ^ sh_r[8] ^ !cfg_r[CFG_EPS]);
   assign brk = allz_r && !rx_in;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_state_r <= RX_IDLE;
         samp_r <= 4'h0;
         bitn_r <= 4'h0;
         sh_r <= 9'h000;
         allz_r <= 1'b0;
         rx_evt_r <= 1'b0;
         rx_ent_r <= 11'h000;
      end else begin
         rx_evt_r <= 1'b0;
         if (tick16_r) begin
            unique case (rx_state_r)
               RX_IDLE: if (!rx_in) begin
                  rx_state_r <= RX_START;
                  samp_r <= 4'h0;
               end
               RX_START: begin
                  samp_r <= samp_r + 4'h1;
                  if (samp_r == MID_TICK) begin
                     samp_r <= 4'h0;
                     bitn_r <= 4'h0;
                     allz_r <= 1'b1;
                     rx_state_r <= rx_in ? RX_IDLE : RX_BITS;
                  end
               end
               RX_BITS: begin
                  samp_r <= samp_r + 4'h1;
                  if (samp_r == LAST_TICK) begin
                     sh_r <= {rx_in, sh_r[8:1]};
                     allz_r <= allz_r & !rx_in;
                     bitn_r <= bitn_r + 4'h1;
                     if (bitn_r == nbits - 4'h1) rx_state_r <= RX_STOP;
                  end
               end
               RX_STOP: begin
                  samp_r <= samp_r + 4'h1;
                  if (samp_r == LAST_TICK) begin
                     rx_evt_r <= 1'b1;
                     samp_r <= 4'h0;
                     // a break yields one zero character only
                     rx_ent_r <= brk ? 11'h600 : {1'b0, !rx_in, rx_pe, rx_data};
                     if (brk) rx_state_r <= RX_BRKW;
                     else if (!rx_in) rx_state_r <= RX_START;
                     else rx_state_r <= RX_IDLE;
                  end
               end
               RX_BRKW: begin
                  samp_r <= rx_in ? samp_r + 4'h1 : 4'h0;
                  if (rx_in && samp_r == HALF_BIT) rx_state_r <= RX_IDLE;
               end
               default: rx_state_r <= RX_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // receive fifo (depth one without fifo mode)
   // ----------------------------------------------------------------
   assign full = cnt_r >= (fifo_en ? FIFO_DEPTH : 5'h01);
   assign pop = rd_go && (rd_idx == IDX_DATA) && (cnt_r != 5'h00);
   assign push = rx_evt_r && (!full || pop);
   assign ovr = rx_evt_r && full && !pop;
   assign ovw = ovr && !fifo_en;
   assign top_ld = ovw || (push && (cnt_r == 5'h00 || (pop && cnt_r == 5'h01)))
                   || (pop && cnt_r > 5'h01);
   assign top_nxt = (pop && cnt_r > 5'h01 && !push) || (pop && cnt_r > 5'h01)
                    ? mem[rd_ptr_r + 4'h1] : rx_ent_r;

   always_ff @(posedge i_ref_clk) begin
      if (push) mem[wr_ptr_r] <= rx_ent_r;
      if (ovw) mem[rd_ptr_r] <= rx_ent_r; // old character destroyed
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_r <= 4'h0;
         rd_ptr_r <= 4'h0;
         cnt_r <= 5'h00;
         err_cnt_r <= 5'h00;
      end else begin
         if (push) wr_ptr_r <= wr_ptr_r + 4'h1;
         if (pop) rd_ptr_r <= rd_ptr_r + 4'h1;
         cnt_r <= cnt_r + {4'h0, push} - {4'h0, pop};
         err_cnt_r <= err_cnt_r + {4'h0, (push || ovw) && umlsb_has_err(rx_ent_r)}
                      - {4'h0, (pop || ovw) && umlsb_has_err(mem[rd_ptr_r])};
      end
   end

   // ----------------------------------------------------------------
   // line status flags (set beats a same-cycle read clear)
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         oe_r <= 1'b0;
         pe_r <= 1'b0;
         fe_r <= 1'b0;
         bi_r <= 1'b0;
      end else begin
         oe_r <= ovr | (oe_r & !lsr_rd);
         pe_r <= (top_ld & top_nxt[8]) | (pe_r & !lsr_rd);
         fe_r <= (top_ld & top_nxt[9]) | (fe_r & !lsr_rd);
         bi_r <= (top_ld & top_nxt[10]) | (bi_r & !lsr_rd);
      end
   end

   assign tx_all_empty = thr_empty_r && !tx_busy_r;
   assign line_condition_flags = {fifo_en && (err_cnt_r != 5'h00), tx_all_empty, thr_empty_r,
                 bi_r, fe_r, pe_r, oe_r, cnt_r != 5'h00};

   // ----------------------------------------------------------------
   // transmitter
   // ----------------------------------------------------------------
   assign thr_wr = wr_go && wstrb_r && (wr_idx == IDX_DATA);
   assign tx_load = !tx_busy_r && !thr_empty_r;
   assign tx_dm = thr_r & mask;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         thr_r <= 8'h00;
         thr_empty_r <= 1'b1;
         tx_busy_r <= 1'b0;
         tx_sh_r <= 11'h7ff;
         tx_samp_r <= 4'h0;
         tx_left_r <= 4'h0;
      end else begin
         if (tx_load) begin
            thr_empty_r <= 1'b1;
            tx_busy_r <= 1'b1;
            tx_samp_r <= 4'h0;
            tx_left_r <= nbits + 4'd2;
            tx_sh_r <= ({3'b000, tx_dm} << 1)
                       | ({10'h000, cfg_r[CFG_PEN] & (^tx_dm ^ !cfg_r[CFG_EPS])}
                          << (nbits))
                       | (11'h7ff << (nbits + 4'd1));
         end else if (tx_busy_r && tick16_r) begin
            tx_samp_r <= tx_samp_r + 4'h1;
            if (tx_samp_r == LAST_TICK) begin
               tx_sh_r <= {1'b1, tx_sh_r[10:1]};
               tx_left_r <= tx_left_r - 4'h1;
               if (tx_left_r == 4'h1) tx_busy_r <= 1'b0;
            end
         end
         if (thr_wr) begin
            thr_r <= wdata_r;
            thr_empty_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // pins and interrupt
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_tx <= 1'b1;
         o_request_to_send_out_n <= 1'b1;
         o_terminal_ready_out_n <= 1'b1;
         o_irq <= 1'b0;
         o_irq_oe <= 1'b0;
      end else begin
         o_tx <= loop | tx_sh_r[0];
         o_request_to_send_out_n <= loop | !mcr_r[MCR_RTS];
         o_terminal_ready_out_n <= loop | !mcr_r[MCR_DTR];
         o_irq <= (cfg_r[CFG_IE_RLS] & (oe_r | pe_r | fe_r | bi_r))
                  | (cfg_r[CFG_IE_RDA] & (cnt_r != 5'h00))
                  | (cfg_r[CFG_IE_THR] & thr_empty_r)
                  | (cfg_r[CFG_IE_MS] & (dl_r != 4'h0));
         o_irq_oe <= mcr_r[MCR_GATE];
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_brk_exit;
      rx_state_r == RX_BRKW ##1 rx_state_r != RX_BRKW;
   endsequence

   AST_RTS_PIN: assert property (1'b1 |=> o_request_to_send_out_n ==
      ($past(loop) || !$past(mcr_r[MCR_RTS]))) else $error("rts pin wrong");
   AST_MCR_HIGH_ZERO: assert property (rd_go && rd_idx == IDX_MCR |=>
      o_rdata[7:5] == 3'b000) else $error("mcr high bits not zero");
   AST_IRQ_GATE: assert property (!mcr_r[MCR_GATE] |=> !o_irq_oe)
      else $error("irq driven while gated");
   AST_LOOP_TX: assert property (loop |=> o_tx) else $error("tx not marking");
   AST_LOOP_MSR: assert property (loop && msr_rd |=> o_rdata[7:4] ==
      {$past(mcr_r[3]), $past(mcr_r[2]), $past(mcr_r[0]), $past(mcr_r[1])})
      else $error("loop msr wrong");
   AST_DR_SET: assert property (push |=> line_condition_flags[0]) else $error("data ready missing");
   AST_OVR_SET: assert property (ovr |=> oe_r) else $error("overrun missed");
   AST_OVR_CLR: assert property (lsr_rd && !ovr |=> !oe_r)
      else $error("overrun not cleared");
   AST_BRK_WAIT: assert property (s_brk_exit |-> rx_state_r == RX_IDLE
      && $past(samp_r) == HALF_BIT && $past(rx_in)) else $error("break exit early");
   AST_TX_HOLD_EMPTY_WR: assert property (thr_wr |=> !thr_empty_r && !line_condition_flags[6])
      else $error("hold empty not cleared");
   AST_TX_LOAD: assert property (tx_load && !thr_wr |=> thr_empty_r ##0 !tx_all_empty)
      else $error("load flags wrong");
   AST_RING: assert property (stat_prev_r[2] && !stat[2] |=> dl_r[2])
      else $error("ring edge missed");
   AST_MS_IRQ: assert property (dl_r != 4'h0 && cfg_r[CFG_IE_MS] |=> o_irq)
      else $error("modem irq missing");
   AST_DIV_RELOAD: assert property (div_wr |=> baud_cnt_r ==
      umlsb_period($past(div_nxt)) - 16'h0001) else $error("divisor reload wrong");
endmodule

/* File: umlsb_peer.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// modem partner: answers terminal ready, echoes the line on request
// ----------------------------------------------------------------
module umlsb_peer (
   input wire logic i_tx,
   input wire logic i_terminal_ready_out_n,
   input wire logic i_echo,
   input wire logic i_brk,
   output logic o_rx,
   output logic o_set_ready_in_n
);
   // marking level while not echoing, so no false start bits
   // a forced break holds spacing level regardless of echo
   assign o_rx = i_brk ? 1'b0 : (i_echo ? i_tx : 1'b1);
   assign o_set_ready_in_n = i_terminal_ready_out_n;
endmodule

/* File: uart_modem_line_status_baud_test.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module uart_modem_line_status_baud_test;
   import umlsb_pkg::*;
   logic ref_clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, arvalid = 0, echo = 0, cts_n = 1;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, got;
   logic [1:0] bresp, rresp, gresp;
   logic awready, wready, bvalid, arready, rvalid, tx, rts_n, dtr_n, irq, irq_oe, baud16;
   logic rx, dsr_n;
   logic brk = 0;
   logic [3:0] whi = '0;
   int mismatches = 0, cmp_count = 0;
   always #10 ref_clk = ~ref_clk;
   umlsb_top u_umlsb_top (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'h1),
      .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
      .i_bready(1'b1), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(1'b1), .i_rx(rx),
      .i_clear_to_send_in_n(cts_n), .i_set_ready_in_n(dsr_n), .i_ring_in_n(1'b1),
      .i_carrier_in_n(1'b1), .o_tx(tx), .o_request_to_send_out_n(rts_n),
      .o_terminal_ready_out_n(dtr_n), .o_irq(irq), .o_irq_oe(irq_oe), .o_baud16(baud16));
   umlsb_peer u_umlsb_peer (.i_tx(tx), .i_terminal_ready_out_n(dtr_n), .i_echo(echo),
      .i_brk(brk), .o_rx(rx), .o_set_ready_in_n(dsr_n));
   // ----------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [3:0] i, input logic [7:0] d);
      logic a, w;
      a = 0;
      w = 0;
      awaddr <= {i, 2'b00};
      wdata <= {20'h0, whi, d};
      awvalid <= 1;
      wvalid <= 1;
      while (!(a && w)) begin
         @(posedge ref_clk);
         a = a | awready;
         w = w | wready;
         awvalid <= !a;
         wvalid <= !w;
      end
      while (!bvalid) @(posedge ref_clk);
      gresp = bresp;
   endtask
   task automatic rd(input logic [3:0] i);
      araddr <= {i, 2'b00};
      arvalid <= 1;
      do @(posedge ref_clk); while (!arready);
      arvalid <= 0;
      do @(posedge ref_clk); while (!rvalid);
      got = rdata;
      gresp = rresp;
   endtask
   task automatic rc(input logic [3:0] i, input logic [7:0] e, input string n);
      rd(i);
      `CHK(n, {24'h0, e}, got)
   endtask
   task automatic edges(input logic [7:0] d, input int e);
      logic p;
      int c;
      wr(IDX_DLL, d);
      @(posedge ref_clk);
      p = baud16;
      c = 0;
      repeat (40) begin
         @(posedge ref_clk);
         c += (baud16 && !p);
         p = baud16;
      end
      `CHK("baud rises", e, c)
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      results();
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1;
      @(posedge ref_clk);
      rc(IDX_LSR, 8'h60, "lsr reset");
      rc(IDX_MSR, 8'h00, "msr reset");
      rc(IDX_DLL, 8'h01, "dll reset");
      wr(IDX_SCR, 8'ha5);
      rc(IDX_SCR, 8'ha5, "scratch");
      rd(4'hb);
      `CHK("unmapped resp", RESP_SLVERR, gresp)
      wr(4'hb, 8'h5a);
      `CHK("unmapped wr resp", RESP_SLVERR, gresp)
      $display("test regs done");
      wr(IDX_MCR, 8'hff);
      rc(IDX_MCR, 8'h1f, "mcr upper");
      `CHK("loop pins", 4'hf, {tx, rts_n, dtr_n, irq_oe})
      rc(IDX_MSR, 8'hfb, "msr loop");
      rc(IDX_MSR, 8'hf0, "msr clear");
      wr(IDX_DATA, 8'h11);
      wr(IDX_DATA, 8'h22);
      // two frames at one tick per clock, then the second char lands
      repeat (500) @(posedge ref_clk);
      rc(IDX_LSR, 8'h63, "lsr overrun");
      rc(IDX_DATA, 8'h22, "loop data");
      rc(IDX_LSR, 8'h60, "lsr clear");
      $display("test loopback done");
      wr(IDX_MCR, 8'h03);
      // pins are registered one edge after the control write lands
      @(posedge ref_clk);
      `CHK("pins active", 4'h8, {tx, rts_n, dtr_n, irq_oe})
      repeat (10) @(posedge ref_clk);
      rd(IDX_MSR);
      rc(IDX_MSR, 8'h20, "msr pins");
      cts_n <= 0;
      repeat (10) @(posedge ref_clk);
      rc(IDX_MSR, 8'h31, "cts change");
      whi = 4'h8;
      wr(IDX_CFG, 8'h03);
      cts_n <= 1;
      repeat (10) @(posedge ref_clk);
      `CHK("modem irq", 2'h2, {irq, irq_oe})
      rc(IDX_MSR, 8'h21, "cts release");
      repeat (2) @(posedge ref_clk);
      `CHK("modem irq clear", 1'b0, irq)
      echo <= 1;
      wr(IDX_DATA, 8'hc3);
      repeat (400) @(posedge ref_clk);
      rc(IDX_DATA, 8'hc3, "echo data");
      // spacing for well over one frame, then marking for the restart wait
      brk <= 1;
      repeat (400) @(posedge ref_clk);
      brk <= 0;
      repeat (100) @(posedge ref_clk);
      rc(IDX_LSR, 8'h79, "lsr break");
      rc(IDX_DATA, 8'h00, "break char");
      rc(IDX_LSR, 8'h60, "lsr break clear");
      $display("test modem done");
      edges(8'h02, 20);
      edges(8'h04, 10);
      $display("test baud done");
      results();
   end
endmodule
